// ===== logic/scg_sysctl.sv
// Operation
// - seven interrupt sources, one bit each
// - only enabled pending sources reach interrupt
// - enable-set mask sets only given bits
// - enable-clear mask clears only given bits
// - raw and masked status views readable
// - oscillator check flags stopped main oscillator
// - failure raises interrupt or resets processor
// - no-crystal setting powers down oscillator circuit
// - gating off clocks peripherals as run
// - gating on follows sleep, deep-sleep enables
// - deep-sleep enable clear stops peripheral clock
// - stopped peripheral resumes with state kept
// - deep-sleep bits kept, ignored when gating off
// - software clear deasserts pending source
// - run enable clear at reset, blocks peripheral
module scg_sysctl
	import scg_pkg::*;
#(
	parameter int NUM_PERIPH = SCG_NUM_PERIPH
)(
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	// axi4-lite write address
	input  wire logic [SCG_ADDR_W-1:0]     s_awaddr,
	input  wire logic                      s_awvalid,
	output logic                           s_awready,
	// axi4-lite write data
	input  wire logic [31:0]               s_wdata,
	input  wire logic [3:0]                s_wstrb,
	input  wire logic                      s_wvalid,
	output logic                           s_wready,
	// axi4-lite write response
	output logic [1:0]                     s_bresp,
	output logic                           s_bvalid,
	input  wire logic                      s_bready,
	// axi4-lite read address
	input  wire logic [SCG_ADDR_W-1:0]     s_araddr,
	input  wire logic                      s_arvalid,
	output logic                           s_arready,
	// axi4-lite read data
	output logic [31:0]                    s_rdata,
	output logic [1:0]                     s_rresp,
	output logic                           s_rvalid,
	input  wire logic                      s_rready,
	// event sources, one-cycle pulses
	input  wire logic                      pll_locked_event,
	input  wire logic                      current_limit_event,
	input  wire logic                      internal_osc_fail_event,
	input  wire logic                      power_on_event,
	input  wire logic                      brown_out_event,
	input  wire logic                      pll_failure_event,
	// main oscillator
	input  wire logic                      main_osc_tick,
	output logic                           crystal_pins_power_down,
	output logic                           processor_reset_req,
	// power mode
	input  wire scg_mode_t                 power_mode,
	// peripheral clock enables
	output logic [NUM_PERIPH-1:0]          periph_clk_en,
	// interrupt
	output logic                           irq
);
	import scg_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [SCG_NUM_SRC-1:0] raw_reg;
	logic [SCG_NUM_SRC-1:0] en_reg;
	logic                   main_osc_check_on;
	logic                   main_osc_fail_irq_not_reset;
	logic                   crystal_absent;
	logic                   sleep_gating_on;
	logic [NUM_PERIPH-1:0]  run_en_reg;
	logic [NUM_PERIPH-1:0]  sleep_en_reg;
	logic [NUM_PERIPH-1:0]  deep_en_reg;
	logic                   osc_fail;
	logic [SCG_NUM_SRC-1:0] events;
	logic [SCG_NUM_SRC-1:0] masked;

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	logic                  aw_held_reg;
	logic                  w_held_reg;
	logic [SCG_ADDR_W-1:0] awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic                  wr_fire;
	logic                  wr_hit;
	logic [31:0]           wmask;

	assign wr_fire = aw_held_reg && w_held_reg && !s_bvalid;
	for (genvar b = 0; b < 4; b++) begin : g_strb
		assign wmask[8*b +: 8] = {8{wstrb_reg[b]}};
	end

	always_comb begin
		unique case (awaddr_reg)
			SCG_OFF_RAW, SCG_OFF_EN_SET, SCG_OFF_EN_CLR, SCG_OFF_OSC_CFG,
			SCG_OFF_GATING, SCG_OFF_RUN_EN, SCG_OFF_SLEEP_EN,
			SCG_OFF_DEEP_EN: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// address and data taken in either order, held until response
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			s_awready   <= 1'b0;
			s_wready    <= 1'b0;
			s_bvalid    <= 1'b0;
			s_bresp     <= SCG_RESP_OKAY;
		end else begin
			s_awready <= !aw_held_reg && !s_awready && !s_bvalid;
			s_wready  <= !w_held_reg && !s_wready && !s_bvalid;
			if (s_awvalid && s_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_awaddr;
				s_awready   <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_wdata;
				wstrb_reg  <= s_wstrb;
				s_wready   <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				s_bvalid    <= 1'b1;
				s_bresp     <= wr_hit ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	logic [31:0] wval;
	assign wval = wdata_reg & wmask;

	// ------------------------------------------------------------
	// interrupt status and enables
	// ------------------------------------------------------------
	always_comb begin
		events = '0;
		events[SCG_SRC_PLL_LOCKED]    = pll_locked_event;
		events[SCG_SRC_CUR_LIMIT]     = current_limit_event;
		events[SCG_SRC_INT_OSC_FAIL]  = internal_osc_fail_event;
		events[SCG_SRC_MAIN_OSC_FAIL] = osc_fail &&
			main_osc_fail_irq_not_reset;
		events[SCG_SRC_POWER_ON]      = power_on_event;
		events[SCG_SRC_BROWN_OUT]     = brown_out_event;
		events[SCG_SRC_PLL_FAILURE]   = pll_failure_event;
	end

	// write-one-to-clear; a new event in the same cycle wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			raw_reg <= '0;
		end else begin
			if (wr_fire && awaddr_reg == SCG_OFF_RAW) begin
				raw_reg <= (raw_reg & ~wval[SCG_NUM_SRC-1:0])
					| events;
			end else begin
				raw_reg <= raw_reg | events;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_reg <= '0;
		end else if (wr_fire && awaddr_reg == SCG_OFF_EN_SET) begin
			en_reg <= en_reg | wval[SCG_NUM_SRC-1:0];
		end else if (wr_fire && awaddr_reg == SCG_OFF_EN_CLR) begin
			en_reg <= en_reg & ~wval[SCG_NUM_SRC-1:0];
		end
	end

	assign masked = raw_reg & en_reg;

	// registered from the current masked value, so irq is a flop that lags raw&en by one cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |masked;
		end
	end

	// ------------------------------------------------------------
	// oscillator and gating settings
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			main_osc_check_on           <= 1'b0;
			main_osc_fail_irq_not_reset <= 1'b0;
			crystal_absent              <= 1'b0;
			sleep_gating_on             <= 1'b0;
		end else if (wr_fire && awaddr_reg == SCG_OFF_OSC_CFG) begin
			main_osc_check_on           <= wval[SCG_OSC_CHECK_BIT];
			main_osc_fail_irq_not_reset <= wval[SCG_OSC_IRQ_BIT];
			crystal_absent              <= wval[SCG_OSC_NOXTAL_BIT];
		end else if (wr_fire && awaddr_reg == SCG_OFF_GATING) begin
			sleep_gating_on <= wval[SCG_GATING_BIT];
		end
	end

	// deep-sleep bits always stored, whatever the gating setting
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_en_reg   <= '0;
			sleep_en_reg <= '0;
			deep_en_reg  <= '0;
		end else if (wr_fire) begin
			if (awaddr_reg == SCG_OFF_RUN_EN) begin
				run_en_reg <= wval[NUM_PERIPH-1:0];
			end
			if (awaddr_reg == SCG_OFF_SLEEP_EN) begin
				sleep_en_reg <= wval[NUM_PERIPH-1:0];
			end
			if (awaddr_reg == SCG_OFF_DEEP_EN) begin
				deep_en_reg <= wval[NUM_PERIPH-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// oscillator supervision
	// ------------------------------------------------------------
	scg_osc_monitor u_mon (
		.clk        (clk),
		.reset_n    (reset_n),
		.check_on   (main_osc_check_on && !crystal_absent),
		.osc_tick   (main_osc_tick),
		.fail_pulse (osc_fail)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			processor_reset_req     <= 1'b0;
			crystal_pins_power_down <= 1'b0;
		end else begin
			processor_reset_req <= osc_fail &&
				!main_osc_fail_irq_not_reset;
			crystal_pins_power_down <= crystal_absent;
		end
	end

	// ------------------------------------------------------------
	// peripheral clock gating
	// ------------------------------------------------------------
	scg_gate_if #(.N(NUM_PERIPH)) gif ();
	assign gif.gating_on = sleep_gating_on;
	assign gif.mode      = power_mode;
	assign gif.run_en    = run_en_reg;
	assign gif.sleep_en  = sleep_en_reg;
	assign gif.deep_en   = deep_en_reg;
	assign periph_clk_en = gif.clk_en;

	scg_clock_gate u_gate (
		.clk     (clk),
		.reset_n (reset_n),
		.g       (gif.gate)
	);

	// ------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------
	logic [31:0] rd_val;
	logic        rd_hit;

	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		unique case (s_araddr)
			SCG_OFF_RAW:      rd_val[SCG_NUM_SRC-1:0] = raw_reg;
			SCG_OFF_MASKED:   rd_val[SCG_NUM_SRC-1:0] = masked;
			SCG_OFF_EN_SET,
			SCG_OFF_EN_CLR:   rd_val[SCG_NUM_SRC-1:0] = en_reg;
			SCG_OFF_OSC_CFG: begin
				rd_val[SCG_OSC_CHECK_BIT]  = main_osc_check_on;
				rd_val[SCG_OSC_IRQ_BIT]    = main_osc_fail_irq_not_reset;
				rd_val[SCG_OSC_NOXTAL_BIT] = crystal_absent;
			end
			SCG_OFF_GATING:   rd_val[SCG_GATING_BIT] = sleep_gating_on;
			SCG_OFF_RUN_EN:   rd_val[NUM_PERIPH-1:0] = run_en_reg;
			SCG_OFF_SLEEP_EN: rd_val[NUM_PERIPH-1:0] = sleep_en_reg;
			SCG_OFF_DEEP_EN:  rd_val[NUM_PERIPH-1:0] = deep_en_reg;
			SCG_OFF_STATUS:   rd_val[NUM_PERIPH-1:0] = periph_clk_en;
			default:          rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= SCG_RESP_OKAY;
		end else begin
			s_arready <= !s_rvalid && !s_arready;
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= rd_val;
				s_rresp   <= rd_hit ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ===== logic/scg_pkg.sv
package scg_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int SCG_NUM_SRC   = 7;
	localparam int SCG_NUM_PERIPH = 16;
	localparam int SCG_ADDR_W    = 6;

	// ------------------------------------------------------------
	// interrupt source bit positions
	// ------------------------------------------------------------
	localparam int SCG_SRC_PLL_LOCKED   = 0;
	localparam int SCG_SRC_CUR_LIMIT    = 1;
	localparam int SCG_SRC_INT_OSC_FAIL = 2;
	localparam int SCG_SRC_MAIN_OSC_FAIL = 3;
	localparam int SCG_SRC_POWER_ON     = 4;
	localparam int SCG_SRC_BROWN_OUT    = 5;
	localparam int SCG_SRC_PLL_FAILURE  = 6;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_RAW      = 6'h00;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_MASKED   = 6'h04;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_EN_SET   = 6'h08;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_EN_CLR   = 6'h0C;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_OSC_CFG  = 6'h10;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_GATING   = 6'h14;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_RUN_EN   = 6'h18;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_SLEEP_EN = 6'h1C;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_DEEP_EN  = 6'h20;
	localparam logic [SCG_ADDR_W-1:0] SCG_OFF_STATUS   = 6'h24;

	// ------------------------------------------------------------
	// oscillator config and gating fields
	// ------------------------------------------------------------
	localparam int SCG_OSC_CHECK_BIT = 0;
	localparam int SCG_OSC_IRQ_BIT   = 1;
	localparam int SCG_OSC_NOXTAL_BIT = 2;
	localparam int SCG_GATING_BIT    = 0;

	// ------------------------------------------------------------
	// supervision timing
	// ------------------------------------------------------------
	localparam int SCG_OSC_TIMEOUT_CYC = 64;
	localparam int SCG_OSC_CNT_W       = 7;

	// ------------------------------------------------------------
	// responses and power modes
	// ------------------------------------------------------------
	localparam logic [1:0] SCG_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SCG_MODE_RUN,
		SCG_MODE_SLEEP,
		SCG_MODE_DEEP
	} scg_mode_t;

endpackage

// ===== logic/scg_gate_if.sv
interface scg_gate_if #(parameter int N = 16);
	logic         gating_on;
	scg_pkg::scg_mode_t mode;
	logic [N-1:0] run_en;
	logic [N-1:0] sleep_en;
	logic [N-1:0] deep_en;
	logic [N-1:0] clk_en;

	modport ctrl (output gating_on, mode, run_en, sleep_en, deep_en,
		input clk_en);
	modport gate (input gating_on, mode, run_en, sleep_en, deep_en,
		output clk_en);
endinterface

// ===== logic/scg_osc_monitor.sv
module scg_osc_monitor
	import scg_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// control
	input  wire logic check_on,
	// oscillator activity
	input  wire logic osc_tick,
	// result
	output logic      fail_pulse
);
	// ------------------------------------------------------------
	// missing-tick watchdog
	// ------------------------------------------------------------
	logic [SCG_OSC_CNT_W-1:0] cnt_reg;
	logic                     tripped_reg;
	localparam logic [SCG_OSC_CNT_W-1:0] LIMIT =
		SCG_OSC_CNT_W'(SCG_OSC_TIMEOUT_CYC);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= '0;
		end else if (!check_on || osc_tick) begin
			cnt_reg <= '0;
		end else if (cnt_reg != LIMIT) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// one pulse per stop; re-armed by a tick or by turning check off
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tripped_reg <= 1'b0;
			fail_pulse  <= 1'b0;
		end else begin
			fail_pulse <= check_on && !tripped_reg &&
				cnt_reg == LIMIT;
			if (!check_on || osc_tick) begin
				tripped_reg <= 1'b0;
			end else if (cnt_reg == LIMIT) begin
				tripped_reg <= 1'b1;
			end
		end
	end
endmodule

// ===== logic/scg_clock_gate.sv
module scg_clock_gate
	import scg_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	scg_gate_if.gate g
);
	// ------------------------------------------------------------
	// per-peripheral enable selection
	// ------------------------------------------------------------
	// registered enable; a real cell-based gate would latch this
	for (genvar i = 0; i < $bits(g.run_en); i++) begin : g_per
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				g.clk_en[i] <= 1'b0;
			end else if (!g.run_en[i]) begin
				g.clk_en[i] <= 1'b0;
			end else if (!g.gating_on || g.mode == SCG_MODE_RUN) begin
				g.clk_en[i] <= 1'b1;
			end else if (g.mode == SCG_MODE_SLEEP) begin
				g.clk_en[i] <= g.sleep_en[i];
			end else begin
				g.clk_en[i] <= g.deep_en[i];
			end
		end
	end
endmodule

// ===== tb/scg_sysctl_properties.sv
module scg_sysctl_properties
	import scg_pkg::*;
#(
	parameter int NUM_PERIPH = SCG_NUM_PERIPH
)(
	// clock and reset
	input wire logic                  clk,
	input wire logic                  reset_n,
	// bus handshakes
	input wire logic                  s_awvalid,
	input wire logic                  s_awready,
	input wire logic                  s_wvalid,
	input wire logic                  s_wready,
	input wire logic [1:0]            s_bresp,
	input wire logic                  s_bvalid,
	input wire logic                  s_bready,
	input wire logic                  s_arvalid,
	input wire logic                  s_arready,
	input wire logic [31:0]           s_rdata,
	input wire logic                  s_rvalid,
	input wire logic                  s_rready,
	// events and oscillator
	input wire logic                  pll_locked_event,
	input wire logic                  current_limit_event,
	input wire logic                  internal_osc_fail_event,
	input wire logic                  power_on_event,
	input wire logic                  brown_out_event,
	input wire logic                  pll_failure_event,
	input wire logic                  main_osc_tick,
	input wire logic                  crystal_pins_power_down,
	input wire logic                  processor_reset_req,
	// mode, gating, interrupt
	input wire scg_mode_t             power_mode,
	input wire logic [NUM_PERIPH-1:0] periph_clk_en,
	input wire logic                  irq
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic       ev_any;
	logic [7:0] idle_cnt_reg;

	assign ev_any = pll_locked_event | current_limit_event |
		internal_osc_fail_event | power_on_event | brown_out_event |
		pll_failure_event;

	// saturates so a long stop never wraps back below the timeout
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			idle_cnt_reg <= 8'h00;
		else if (main_osc_tick)
			idle_cnt_reg <= 8'h00;
		else if (idle_cnt_reg != 8'hFF)
			idle_cnt_reg <= idle_cnt_reg + 8'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	write_answer_a: assert property (s_awvalid && s_awready && s_wvalid &&
		s_wready |-> ##2 s_bvalid) else $error("write answer late");
	bresp_holds_a: assert property (s_bvalid && !s_bready |=>
		s_bvalid && $stable(s_bresp)) else $error("bresp dropped");
	read_answer_a: assert property (s_arvalid && s_arready |=>
		s_rvalid) else $error("read answer late");
	rdata_holds_a: assert property (s_rvalid && !s_rready |=>
		s_rvalid && $stable(s_rdata)) else $error("rdata dropped");
	irq_rise_cause_a: assert property ($rose(irq) |->
		$past(ev_any, 2) || $past(s_bvalid) ||
		$past(idle_cnt_reg) >= 8'h40)
		else $error("irq rose without cause");
	irq_fall_cause_a: assert property ($fell(irq) |->
		$past(s_bvalid)) else $error("irq fell without write");
	reset_one_pulse_a: assert property (processor_reset_req |=>
		!processor_reset_req) else $error("reset request too long");
	reset_after_idle_a: assert property (processor_reset_req |->
		idle_cnt_reg >= 8'h40) else $error("reset request early");
	xtal_by_write_a: assert property ($changed(crystal_pins_power_down)
		|-> $past(s_bvalid)) else $error("power down moved alone");
	clk_en_cause_a: assert property ($changed(periph_clk_en) |->
		$past(s_bvalid) || $past(power_mode) != $past(power_mode, 2))
		else $error("clock enable moved alone");

	cover property ($rose(irq));
	cover property (processor_reset_req);
	cover property ($changed(periph_clk_en));
endmodule

bind scg_sysctl scg_sysctl_properties #(.NUM_PERIPH(NUM_PERIPH)) u_props (
	.clk, .reset_n, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
	.s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata,
	.s_rvalid, .s_rready, .pll_locked_event, .current_limit_event,
	.internal_osc_fail_event, .power_on_event, .brown_out_event,
	.pll_failure_event, .main_osc_tick, .crystal_pins_power_down,
	.processor_reset_req, .power_mode, .periph_clk_en, .irq
);

// ===== tb/scg_sysctl_tb_top.sv
module scg_sysctl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scg_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                  clk, reset_n, main_osc_tick;
	logic [SCG_ADDR_W-1:0] s_awaddr, s_araddr;
	logic                  s_awvalid, s_awready, s_wvalid, s_wready;
	logic                  s_bvalid, s_bready, s_arvalid, s_arready;
	logic                  s_rvalid, s_rready, irq;
	logic                  crystal_pins_power_down, processor_reset_req;
	logic [31:0]           s_wdata, s_rdata, rdat;
	logic [3:0]            s_wstrb, wstrb_sel;
	logic [1:0]            s_bresp, s_rresp, lresp;
	logic [5:0]            ev;
	logic [15:0]           periph_clk_en, e;
	scg_mode_t             power_mode;
	int                    n_errors, samples_checked, rst_pulses;

	scg_sysctl #(.NUM_PERIPH(16)) u_scg_sysctl (
		.clk(clk), .reset_n(reset_n),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready),
		.pll_locked_event(ev[0]), .current_limit_event(ev[1]),
		.internal_osc_fail_event(ev[2]), .power_on_event(ev[3]),
		.brown_out_event(ev[4]), .pll_failure_event(ev[5]),
		.main_osc_tick(main_osc_tick),
		.crystal_pins_power_down(crystal_pins_power_down),
		.processor_reset_req(processor_reset_req),
		.power_mode(power_mode), .periph_clk_en(periph_clk_en), .irq(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
		if (processor_reset_req === 1'b1)
			rst_pulses++;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [SCG_ADDR_W-1:0] a, input logic [31:0] d);
		bit a_d, w_d;
		int t;
		a_d = 0;
		w_d = 0;
		t = 0;
		@(posedge clk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wstrb <= wstrb_sel;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(a_d && w_d) && t < 50) begin
			@(posedge clk);
			t++;
			if (!a_d && s_awready === 1'b1) begin
				a_d = 1;
				s_awvalid <= 1'b0;
			end
			if (!w_d && s_wready === 1'b1) begin
				w_d = 1;
				s_wvalid <= 1'b0;
			end
		end
		while (s_bvalid !== 1'b1 && t < 100) begin
			@(posedge clk);
			t++;
		end
		lresp = s_bresp;
		s_bready <= 1'b0;
		if (t >= 100)
			n_errors++;
	endtask

	task automatic rd(input logic [SCG_ADDR_W-1:0] a);
		int t;
		t = 0;
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk);
			t++;
		end while (s_arready !== 1'b1 && t < 50);
		s_arvalid <= 1'b0;
		do begin
			@(posedge clk);
			t++;
		end while (s_rvalid !== 1'b1 && t < 100);
		rdat = s_rdata;
		lresp = s_rresp;
		s_rready <= 1'b0;
		if (t >= 100)
			n_errors++;
	endtask

	task automatic rc(input logic [SCG_ADDR_W-1:0] a, input logic [31:0] x);
		rd(a);
		chk(rdat, x);
	endtask

	task automatic final_report;
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{reset_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
		{s_awaddr, s_araddr, s_wdata, s_wstrb, ev} = '0;
		power_mode = SCG_MODE_RUN;
		wstrb_sel = 4'hF;
		main_osc_tick = 1'b1;
		{n_errors, samples_checked, rst_pulses} = '0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		rc(SCG_OFF_EN_SET, 32'h0);
		rc(SCG_OFF_OSC_CFG, 32'h0);
		rc(SCG_OFF_GATING, 32'h0);
		rc(SCG_OFF_RUN_EN, 32'h0);
		rc(SCG_OFF_STATUS, 32'h0);
		@(posedge clk) ev <= 6'h3F;
		@(posedge clk) ev <= 6'h00;
		rc(SCG_OFF_RAW, 32'h77);
		rc(SCG_OFF_MASKED, 32'h0);
		chk(irq, 1'b0);
		wr(SCG_OFF_EN_SET, 32'h11);
		wr(SCG_OFF_EN_SET, 32'h02);
		chk(lresp, SCG_RESP_OKAY);
		rc(SCG_OFF_EN_SET, 32'h13);
		rc(SCG_OFF_MASKED, 32'h13);
		chk(irq, 1'b1);
		wr(SCG_OFF_EN_CLR, 32'h10);
		rc(SCG_OFF_EN_CLR, 32'h03);
		rc(SCG_OFF_MASKED, 32'h03);
		wr(SCG_OFF_RAW, 32'h77);
		rc(SCG_OFF_RAW, 32'h0);
		chk(irq, 1'b0);
		// read-only and unmapped places refuse
		wr(SCG_OFF_MASKED, 32'h1);
		chk(lresp, SCG_RESP_SLVERR);
		rd(6'h28);
		chk(lresp, SCG_RESP_SLVERR);
		chk(rdat, 32'h0);
		// stopped oscillator, interrupt response
		wr(SCG_OFF_EN_SET, 32'h08);
		wr(SCG_OFF_OSC_CFG, 32'h3);
		main_osc_tick <= 1'b0;
		repeat (80) @(posedge clk);
		rc(SCG_OFF_RAW, 32'h08);
		chk({irq, rst_pulses[7:0]}, 9'h100);
		// stopped oscillator, reset response; a tick re-arms
		wr(SCG_OFF_RAW, 32'h08);
		wr(SCG_OFF_OSC_CFG, 32'h1);
		main_osc_tick <= 1'b1;
		repeat (3) @(posedge clk);
		main_osc_tick <= 1'b0;
		repeat (80) @(posedge clk);
		chk(rst_pulses, 1);
		rc(SCG_OFF_RAW, 32'h0);
		// a masked-off strobe lane must add no enables
		wstrb_sel = 4'h2;
		wr(SCG_OFF_EN_SET, 32'h04);
		wstrb_sel = 4'hF;
		rc(SCG_OFF_EN_SET, 32'h0B);
		wr(SCG_OFF_OSC_CFG, 32'h4);
		repeat (2) @(posedge clk);
		chk(crystal_pins_power_down, 1'b1);
		// gating: bit 4 is sleep-enabled but not run-enabled
		wr(SCG_OFF_RUN_EN, 32'h000F);
		wr(SCG_OFF_SLEEP_EN, 32'h0013);
		wr(SCG_OFF_DEEP_EN, 32'h0005);
		for (int g = 0; g < 2; g++) begin
			wr(SCG_OFF_GATING, g);
			for (int m = 0; m < 3; m++) begin
				power_mode <= scg_mode_t'(m);
				repeat (3) @(posedge clk);
				e = (g == 0 || m == 0) ? 16'h000F :
					(m == 1) ? 16'h0003 : 16'h0005;
				chk(periph_clk_en, e);
			end
		end
		rc(SCG_OFF_STATUS, 32'h0005);
		rc(SCG_OFF_DEEP_EN, 32'h0005);
		power_mode <= SCG_MODE_RUN;
		repeat (3) @(posedge clk);
		chk(periph_clk_en, 16'h000F);
		final_report;
	end

	// whole run is about 340 cycles; allow generous slack
	initial begin
		repeat (10000) @(posedge clk);
		n_errors++;
		final_report;
	end
endmodule
